/* upc_phy_control.sv */
`timescale 1ns/1ps
// Function
// - writing 1 to bit 18 switches off the pulldowns of both wide ports, reset 0.
// - an automatic resume by SE0 sets the reset-resume flag, held until written 0.
// - an automatic resume by K sets the K-resume flag, held until written 0.
// - a line-state change passes only after 2**field[11:8] stable clock cycles.
// - bit 7 set lets hardware resume from suspend, clear leaves software to poll line state.
// - bits 6:4 drive the three transceiver configuration pins, reset 0.
module upc_phy_control (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [upc_pkg::upc_addr_w-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [upc_pkg::upc_addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // transceiver
   input wire logic [1:0] line_state,
   input wire logic suspended,
   output logic [2:0] transceiver_config_pins,
   output logic wide_port_a_pd_dis,
   output logic wide_port_b_pd_dis,
   output logic hw_resume,
   // interrupt
   output logic irq
);
   import upc_pkg::*;
   upc_filt_if fi ();
   logic [31:0] ctrl, next_ctrl;
   logic [2:0] irq_st, next_irq_st;
   logic [2:0] irq_en, next_irq_en;
   logic [1:0] ls_s1, ls_s2, ls_s3;
   logic susp_s1, susp_s2, susp_s3, susp_q, next_susp_q;
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [upc_addr_w-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic do_wr, res_se0, res_k;
   logic [31:0] wmask;

   function automatic logic known(input logic [upc_addr_w-1:0] a);
      return a == upc_off_phy_control || a == upc_off_irq_status
         || a == upc_off_irq_enable || a == upc_off_irq_clear || a == upc_off_line_status;
   endfunction : known

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : strb_mask

   // three-stage pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ls_s1 <= 2'h0;
         ls_s2 <= 2'h0;
         ls_s3 <= 2'h0;
         susp_s1 <= 1'b0;
         susp_s2 <= 1'b0;
         susp_s3 <= 1'b0;
      end else begin
         ls_s1 <= line_state;
         ls_s2 <= ls_s1;
         ls_s3 <= ls_s2;
         susp_s1 <= suspended;
         susp_s2 <= susp_s1;
         susp_s3 <= susp_s2;
      end
   end

   assign fi.log2_len = ctrl[upc_pos_filt_lo +: 4];
   assign fi.raw = (ls_s2 == ls_s3) ? ls_s3 : fi.filt;
   upc_line_filter u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .f(fi.filt_end)
   );

   assign res_se0 = ctrl[upc_pos_susp_hw] && susp_q && fi.change
      && fi.filt == 2'(upc_ls_se0);
   assign res_k = ctrl[upc_pos_susp_hw] && susp_q && fi.change
      && fi.filt == 2'(upc_ls_k);
   assign hw_resume = res_se0 || res_k;

   assign do_wr = aw_held && w_held && !bvalid;
   assign wmask = strb_mask(w_strb);

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_ctrl = ctrl;
      next_irq_en = irq_en;
      next_irq_st = irq_st;
      next_susp_q = ctrl[upc_pos_susp_hw] ? (susp_s3 && !hw_resume) : 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_wr) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = known(aw_addr) ? upc_resp_okay : upc_resp_slverr;
         unique case (aw_addr)
            upc_off_phy_control: begin
               next_ctrl = (ctrl & ~(wmask & upc_ctrl_rw_mask))
                  | (w_data & wmask & upc_ctrl_rw_mask);
            end
            upc_off_irq_enable: begin
               next_irq_en = (irq_en & ~wmask[2:0]) | (w_data[2:0] & wmask[2:0]);
            end
            upc_off_irq_clear: begin
               next_irq_st = irq_st & ~(w_data[2:0] & wmask[2:0]);
            end
            default: begin
            end
         endcase
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (res_se0) begin
         next_ctrl[upc_pos_rst_resume] = 1'b1;
      end
      if (res_k) begin
         next_ctrl[upc_pos_k_resume] = 1'b1;
      end
      next_irq_st = next_irq_st | {fi.change, res_k, res_se0};
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = known(s_axi_araddr) ? upc_resp_okay : upc_resp_slverr;
         unique case (s_axi_araddr)
            upc_off_phy_control: next_rdata = ctrl & upc_ctrl_rw_mask;
            upc_off_irq_status: next_rdata = {29'h0, irq_st};
            upc_off_irq_enable: next_rdata = {29'h0, irq_en};
            upc_off_line_status: next_rdata = {29'h0, susp_q, fi.filt};
            default: next_rdata = 32'h0000_0000;
         endcase
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= upc_ctrl_reset;
         irq_st <= upc_irq_reset;
         irq_en <= upc_irq_reset;
         susp_q <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= upc_resp_okay;
         rvalid <= 1'b0;
         rresp <= upc_resp_okay;
         rdata <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         irq_st <= next_irq_st;
         irq_en <= next_irq_en;
         susp_q <= next_susp_q;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;
   assign transceiver_config_pins = ctrl[upc_pos_cfg_lo +: 3];
   assign wide_port_a_pd_dis = ctrl[upc_pos_pd_dis];
   assign wide_port_b_pd_dis = ctrl[upc_pos_pd_dis];
   assign irq = |(irq_st & irq_en);
endmodule : upc_phy_control

/* upc_pkg.sv */
package upc_pkg;
   localparam int unsigned upc_addr_w = 8;
   localparam logic [7:0] upc_off_phy_control = 8'h40;
   localparam logic [7:0] upc_off_irq_status = 8'h44;
   localparam logic [7:0] upc_off_irq_enable = 8'h48;
   localparam logic [7:0] upc_off_irq_clear = 8'h4c;
   localparam logic [7:0] upc_off_line_status = 8'h50;
   localparam int unsigned upc_pos_pd_dis = 18;
   localparam int unsigned upc_pos_rst_resume = 13;
   localparam int unsigned upc_pos_k_resume = 12;
   localparam int unsigned upc_pos_filt_lo = 8;
   localparam int unsigned upc_pos_susp_hw = 7;
   localparam int unsigned upc_pos_cfg_lo = 4;
   localparam logic [31:0] upc_ctrl_rw_mask = 32'h0004_3ff0;
   localparam logic [31:0] upc_ctrl_reset = 32'h0000_0000;
   localparam logic [3:0] upc_filt_reset = 4'h0;
   localparam logic [2:0] upc_cfg_reset = 3'h0;
   localparam logic [2:0] upc_irq_reset = 3'h0;
   localparam int unsigned upc_irq_w = 3;
   localparam logic [1:0] upc_resp_okay = 2'h0;
   localparam logic [1:0] upc_resp_slverr = 2'h2;
   typedef enum logic [1:0] {upc_ls_se0, upc_ls_j, upc_ls_k, upc_ls_se1} upc_ls_e;
endpackage : upc_pkg

/* upc_filt_if.sv */
`timescale 1ns/1ps
interface upc_filt_if;
   logic [3:0] log2_len;
   logic [1:0] raw;
   logic [1:0] filt;
   logic change;
   modport ctrl (output log2_len, output raw, input filt, input change);
   modport filt_end (input log2_len, input raw, output filt, output change);
endinterface : upc_filt_if

/* upc_line_filter.sv */
`timescale 1ns/1ps
module upc_line_filter (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // filter side
   upc_filt_if.filt_end f
);
   import upc_pkg::*;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [1:0] filt;
   logic [1:0] next_filt;
   logic change;
   logic next_change;
   logic [15:0] need;
   always_comb begin
      need = 16'h0001 << f.log2_len;
      next_cnt = 16'h0000;
      next_filt = filt;
      next_change = 1'b0;
      if (f.raw != filt) begin
         next_cnt = cnt + 16'h0001;
         if ((cnt + 16'h0001) >= need) begin
            next_filt = f.raw;
            next_change = 1'b1;
            next_cnt = 16'h0000;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 16'h0000;
         filt <= 2'(upc_ls_se0);
         change <= 1'b0;
      end else begin
         cnt <= next_cnt;
         filt <= next_filt;
         change <= next_change;
      end
   end
   assign f.filt = filt;
   assign f.change = change;
endmodule : upc_line_filter

/* upc_phy_control_monitor.sv */
`timescale 1ns/1ps
module upc_phy_control_monitor (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // transceiver side
   input wire logic [2:0] transceiver_config_pins,
   input wire logic wide_port_a_pd_dis,
   input wire logic wide_port_b_pd_dis,
   input wire logic hw_resume
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_pd_pair: assert property (
      wide_port_a_pd_dis == wide_port_b_pd_dis) else $error("pulldown disables differ");
   chk_reset_pins: assert property (
      $rose(aresetn) |-> !wide_port_a_pd_dis && transceiver_config_pins == 3'h0)
      else $error("pins not zero after reset");
   chk_cfg_on_write: assert property (
      $changed(transceiver_config_pins) |-> $rose(s_axi_bvalid))
      else $error("config pins moved without a write");
   chk_resume_pulse: assert property (
      hw_resume |=> !hw_resume) else $error("resume pulse too long");
   chk_read_lat: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   chk_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   chk_aw_block: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("address slot not held");
endmodule : upc_phy_control_monitor
bind upc_phy_control upc_phy_control_monitor u_mon (.*);

/* upc_xcvr_model.sv */
`timescale 1ns/1ps
module upc_xcvr_model (
   // clock
   input wire logic aclk,
   // bench commands
   input wire logic [1:0] want,
   input wire logic sus_req,
   // pins
   output logic [1:0] line_state,
   output logic suspended
);
   always @(posedge aclk) begin
      line_state <= want;
      suspended <= sus_req;
   end
endmodule : upc_xcvr_model

/* upc_phy_control_tb.sv */
`timescale 1ns/1ps
module upc_phy_control_tb;
   import upc_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, sus_req = 0, suspended;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic hw_resume, irq, wide_port_a_pd_dis, wide_port_b_pd_dis;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h3e, d, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, line_state, want = 2'h1, rs;
   logic [2:0] transceiver_config_pins;
   int num_errors = 0, samples_checked = 0, pulses = 0, p0 = 0;
   upc_phy_control dut (.*);
   upc_xcvr_model u_xcvr (.*);
   always #10 aclk = ~aclk;
   always @(posedge aclk) if (aresetn && hw_resume === 1'b1) pulses <= pulses + 1;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat (2) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd_reg
   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_reg(upc_off_phy_control, rd, rs);
      chk("ctrl_reset", upc_ctrl_reset, rd);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         d = (i == 0) ? 32'hffff_ffff : seed;
         wr(upc_off_phy_control, d, rs);
         rd_reg(upc_off_phy_control, rd, rs);
         chk("ctrl", d & upc_ctrl_rw_mask, rd);
         chk("cfg_pins", {29'h0, d[6:4]}, {29'h0, transceiver_config_pins});
         chk("pd", {30'h0, {2{d[18]}}}, {30'h0, wide_port_a_pd_dis, wide_port_b_pd_dis});
      end
      // byte lane 1 only: filter field and both flags
      s_axi_wstrb <= 4'h2;
      wr(upc_off_phy_control, 32'hffff_ffff, rs);
      s_axi_wstrb <= 4'hf;
      rd_reg(upc_off_phy_control, rd, rs);
      chk("ctrl_strb", (d & upc_ctrl_rw_mask & ~32'h0000_ff00) | (32'h0000_ff00 & upc_ctrl_rw_mask), rd);
      wr(8'h00, 32'hffff_ffff, rs);
      chk("bresp_bad", {30'h0, upc_resp_slverr}, {30'h0, rs});
      rd_reg(8'h3c, rd, rs);
      chk("rresp_bad", {30'h0, upc_resp_slverr}, {30'h0, rs});
      wr(upc_off_phy_control, 32'h0000_0300, rs);
      wr(upc_off_irq_clear, 32'h7, rs);
      want <= upc_ls_k;
      repeat (6) @(posedge aclk);
      want <= upc_ls_j;
      repeat (20) @(posedge aclk);
      rd_reg(upc_off_line_status, rd, rs);
      chk("line_glitch", {30'h0, upc_ls_j}, {30'h0, rd[1:0]});
      want <= upc_ls_k;
      repeat (20) @(posedge aclk);
      rd_reg(upc_off_line_status, rd, rs);
      chk("line_pass", {30'h0, upc_ls_k}, {30'h0, rd[1:0]});
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(upc_off_irq_enable, 32'h4, rs);
      chk("irq_on", 32'h1, {31'h0, irq});
      wr(upc_off_irq_clear, 32'h4, rs);
      chk("irq_off", 32'h0, {31'h0, irq});
      for (int m = 0; m < 2; m++) begin
         want <= upc_ls_j;
         wr(upc_off_phy_control, 32'h0000_0080, rs);
         sus_req <= 1'b1;
         p0 = pulses;
         repeat (10) @(posedge aclk);
         want <= m ? upc_ls_se0 : upc_ls_k;
         repeat (10) @(posedge aclk);
         sus_req <= 1'b0;
         rd_reg(upc_off_phy_control, rd, rs);
         chk("resume_flag", m ? 32'h2080 : 32'h1080, rd);
         chk("hw_pulses", 32'h1, pulses - p0);
      end
      rd_reg(upc_off_irq_status, rd, rs);
      chk("irq_status", 32'h7, rd);
      final_report();
   end
endmodule : upc_phy_control_tb
